// ### design/apc_clock_gen.sv
// converter clock source select and divider, as a tick in the bus domain
`timescale 1ns/1ps
module apc_clock_gen
  import apc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] inputClockSelect,
  input  wire logic [1:0] clockDivideField,
  input  wire logic       alternateClock,
  input  wire logic       asyncClockRun,
  output logic            converterTick
);
  logic [1:0] altSync;
  logic       altPrev;
  logic       halfToggle;
  logic [7:0] asyncCount;
  logic [2:0] divCount;
  logic       srcTick;
  logic [2:0] divLimit;
  logic       next_halfToggle;
  logic [7:0] next_asyncCount;
  logic [2:0] next_divCount;
  logic       next_converterTick;

  always_comb begin
    next_halfToggle = ~halfToggle;
    next_asyncCount = asyncCount;
    if (asyncClockRun) begin
      // internal oscillator keeps going in wait and stop3 when selected
      if (asyncCount == 8'(ASYNC_DIV_CYCLES - 1)) next_asyncCount = 8'h00;
      else next_asyncCount = asyncCount + 8'h01;
    end
    unique case (inputClockSelect)
      ICLK_BUS:      srcTick = 1'b1;
      ICLK_BUS_HALF: srcTick = halfToggle;
      ICLK_ALT:      srcTick = altSync[1] & ~altPrev;
      ICLK_ASYNC:    srcTick = asyncClockRun &&
                               asyncCount == 8'(ASYNC_DIV_CYCLES - 1);
    endcase
    divLimit = 3'((4'h1 << clockDivideField) - 4'h1);
    next_divCount = divCount;
    next_converterTick = 1'b0;
    if (srcTick) begin
      if (divCount >= divLimit) begin
        next_divCount = 3'h0;
        next_converterTick = 1'b1;
      end else begin
        next_divCount = divCount + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      altSync       <= 2'h0;
      altPrev       <= 1'b0;
      halfToggle    <= 1'b0;
      asyncCount    <= 8'h00;
      divCount      <= 3'h0;
      converterTick <= 1'b0;
    end else begin
      altSync       <= {altSync[0], alternateClock};
      altPrev       <= altSync[1];
      halfToggle    <= next_halfToggle;
      asyncCount    <= next_asyncCount;
      divCount      <= next_divCount;
      converterTick <= next_converterTick;
    end
  end

  // bus clock over eight: seven quiet cycles while the setting holds
  div_eight_a: assert property (@(posedge clk) disable iff (!resetn)
    (converterTick && inputClockSelect == ICLK_BUS &&
     clockDivideField == DIV_8 && $stable(clockDivideField) &&
     $stable(inputClockSelect)) |=> (!converterTick ||
     clockDivideField != DIV_8 || inputClockSelect != ICLK_BUS) [*7])
    else $error("divide by eight tick spacing wrong");
endmodule : apc_clock_gen

// ### design/apc_converter_control.sv
// converter control top: registers, pins, clocking, result and flag
//
// Overview of operation
// - pin control mid register bits 7..0 steer channels 7..0.
// - pin control high register bits 7..0 steer channels 15..8.
// - bit 0 keeps port control of the pin, bit 1 removes it.
// - converter disabled during reset or when channel select is all ones.
// - after completion and before a new start, converter idles powered down.
// - 12-bit and 10-bit modes convert to a 12-bit raw value.
// - 8-bit mode converts to a 9-bit raw value.
// - 10-bit mode rounds to 10 bits across high and low result.
// - 8-bit mode rounds to 8 bits, stored only in low result.
// - storing a result sets complete flag; interrupt when enable is one.
// - compare enable gates result storage on compare, in every mode.
// - one of four sources is selected then divided into converter clock.
// - after reset the bus clock is the selected source.
// - bus clock over two source allows total division up to 16.
// - internal asynchronous clock runs through wait and stop3 when selected.
// - divider ratio is 1, 2, 4 or 8 from the divide field.
// - source codes: 00 bus, 01 bus over two, 10 alternate, 11 async.
// - divide codes: 00 by 1, 01 by 2, 10 by 4, 11 by 8.
// - mode codes: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// - disabled pin: output high impedance, port reads zero, no pullup.
`timescale 1ns/1ps
module apc_converter_control
  import apc_pkg::*;
#(
  parameter int PIN_CH = 16
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [3:0]        busAddr,
  input  wire logic [7:0]        busWriteData,
  input  wire logic              busWrite,
  input  wire logic              busRead,
  output logic [7:0]             busReadData,
  input  wire logic              alternateClock,
  input  wire logic              waitMode,
  input  wire logic              stop3Mode,
  input  wire logic              comparatorHigh,
  input  wire logic [PIN_CH-1:0] portOutputEnable,
  input  wire logic [PIN_CH-1:0] portPullupEnable,
  input  wire logic [PIN_CH-1:0] padInput,
  output logic [PIN_CH-1:0]      padOutputEnable,
  output logic [PIN_CH-1:0]      padPullupEnable,
  output logic [PIN_CH-1:0]      portReadData,
  output logic [4:0]             sampleChannel,
  output logic [11:0]            trialCode,
  output logic                   converterActive,
  output logic                   converterEnabled,
  output logic                   asyncClockRun,
  output logic                   interruptRequest
);
  // register state
  logic                conversionCompleteFlag, completeInterruptEnable;
  logic                compareEnableBit, compareGreaterEqual;
  logic [7:0]          config_, compareHigh, compareLow;
  logic [3:0]          resultHigh;
  logic [7:0]          resultLow;
  logic [7:0]          analogPinControlMid, analogPinControlHigh;
  logic                next_conversionCompleteFlag;
  logic                next_completeInterruptEnable;
  logic                next_compareEnableBit, next_compareGreaterEqual;
  logic [7:0]          next_config, next_compareHigh, next_compareLow;
  logic [3:0]          next_resultHigh;
  logic [7:0]          next_resultLow;
  logic [7:0]          next_analogPinControlMid, next_analogPinControlHigh;
  logic [4:0]          next_sampleChannel;
  logic [7:0]          next_busReadData;
  logic [PIN_CH-1:0]   padSyncMeta, padSync, pinDisable;
  // converter datapath
  logic [1:0]          modeField, inputClockSelect, clockDivideField;
  logic                converterTick, sarBusy, sarDone;
  logic [11:0]         rawResult;
  logic                startConv, abortConv;
  logic                writeHit, readLowHit;
  logic [12:0]         roundTen;
  logic [9:0]          roundEight;
  logic [11:0]         shapedResult, shapedCompare;
  logic [3:0]          candHigh;
  logic [7:0]          candLow;
  logic                compareHit, storeResult;

  assign modeField        = config_[CFG_MODE_LSB +: 2];
  assign inputClockSelect = config_[CFG_ICLK_LSB +: 2];
  assign clockDivideField = config_[CFG_DIV_LSB +: 2];
  assign pinDisable = {analogPinControlHigh, analogPinControlMid};

  apc_clock_gen u_clock_gen (
    .clk              (clk),
    .resetn           (resetn),
    .inputClockSelect (inputClockSelect),
    .clockDivideField (clockDivideField),
    .alternateClock   (alternateClock),
    .asyncClockRun    (asyncClockRun),
    .converterTick    (converterTick)
  );

  apc_sar u_sar (
    .clk            (clk),
    .resetn         (resetn),
    .start          (startConv),
    .abort          (abortConv),
    .converterTick  (converterTick),
    .eightBitMode   (modeField == MODE_8BIT),
    .comparatorHigh (comparatorHigh),
    .busy           (sarBusy),
    .done           (sarDone),
    .rawResult      (rawResult),
    .trialCode      (trialCode)
  );

  // bus decode, start and abort
  always_comb begin
    writeHit   = busWrite;
    readLowHit = busRead && busAddr == OFS_RESULT_LOW;
    startConv  = busWrite && busAddr == OFS_STATUS_CONTROL &&
                 busWriteData[4:0] != CHAN_DISABLED;
    abortConv  = busWrite && (busAddr == OFS_STATUS_CONTROL ||
                 busAddr == OFS_COMPARE_CONTROL || busAddr == OFS_CONFIG ||
                 busAddr == OFS_COMPARE_HIGH || busAddr == OFS_COMPARE_LOW);
  end

  // rounding and compare of the finished conversion
  always_comb begin
    roundTen   = {1'b0, rawResult} + 13'h0002;
    roundEight = {1'b0, rawResult[11:3]} + 10'h001;
    candHigh   = resultHigh;
    candLow    = resultLow;
    unique case (modeField)
      MODE_12BIT: begin
        candHigh = rawResult[11:8];
        candLow  = rawResult[7:0];
      end
      MODE_10BIT: begin
        candHigh = roundTen[12] ? 4'h3 : {2'h0, roundTen[11:10]};
        candLow  = roundTen[12] ? 8'hff : roundTen[9:2];
      end
      MODE_8BIT: candLow = roundEight[9] ? 8'hff : roundEight[8:1];
      default: ;
    endcase
    shapedResult  = (modeField == MODE_8BIT) ? {4'h0, candLow}
                                             : {candHigh, candLow};
    unique case (modeField)
      MODE_8BIT:  shapedCompare = {4'h0, compareLow};
      MODE_10BIT: shapedCompare = {2'h0, compareHigh[1:0], compareLow};
      default:    shapedCompare = {compareHigh[3:0], compareLow};
    endcase
    compareHit  = compareGreaterEqual ? shapedResult >= shapedCompare
                                      : shapedResult <  shapedCompare;
    storeResult = sarDone && (!compareEnableBit || compareHit);
  end

  // register writes, result store and complete flag
  always_comb begin
    next_completeInterruptEnable = completeInterruptEnable;
    next_sampleChannel           = sampleChannel;
    next_compareEnableBit        = compareEnableBit;
    next_compareGreaterEqual     = compareGreaterEqual;
    next_config                  = config_;
    next_compareHigh             = compareHigh;
    next_compareLow              = compareLow;
    next_analogPinControlMid     = analogPinControlMid;
    next_analogPinControlHigh    = analogPinControlHigh;
    next_resultHigh              = resultHigh;
    next_resultLow               = resultLow;
    next_conversionCompleteFlag  = conversionCompleteFlag;
    if (writeHit) begin
      unique case (busAddr)
        OFS_STATUS_CONTROL: begin
          next_completeInterruptEnable = busWriteData[IEN_BIT];
          next_sampleChannel           = busWriteData[4:0];
          next_conversionCompleteFlag  = 1'b0;
        end
        OFS_COMPARE_CONTROL: begin
          next_compareEnableBit    = busWriteData[CMP_EN_BIT];
          next_compareGreaterEqual = busWriteData[CMP_GE_BIT];
        end
        OFS_CONFIG:       next_config = busWriteData;
        OFS_COMPARE_HIGH: next_compareHigh = busWriteData;
        OFS_COMPARE_LOW:  next_compareLow = busWriteData;
        OFS_PIN_CTL_MID:  next_analogPinControlMid = busWriteData;
        OFS_PIN_CTL_HIGH: next_analogPinControlHigh = busWriteData;
        default: ;
      endcase
    end
    if (readLowHit) next_conversionCompleteFlag = 1'b0;
    if (storeResult) begin
      next_resultHigh = candHigh;
      next_resultLow  = candLow;
      next_conversionCompleteFlag = 1'b1;
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    next_busReadData = 8'h00;
    if (busRead) begin
      unique case (busAddr)
        OFS_STATUS_CONTROL: next_busReadData = {conversionCompleteFlag,
          completeInterruptEnable, 1'b0, sampleChannel};
        OFS_COMPARE_CONTROL: next_busReadData = {2'h0, compareEnableBit,
          compareGreaterEqual, 4'h0};
        OFS_RESULT_HIGH:  next_busReadData = {4'h0, resultHigh};
        OFS_RESULT_LOW:   next_busReadData = resultLow;
        OFS_COMPARE_HIGH: next_busReadData = compareHigh;
        OFS_COMPARE_LOW:  next_busReadData = compareLow;
        OFS_CONFIG:       next_busReadData = config_;
        OFS_PIN_CTL_MID:  next_busReadData = analogPinControlMid;
        OFS_PIN_CTL_HIGH: next_busReadData = analogPinControlHigh;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conversionCompleteFlag  <= 1'b0;
      completeInterruptEnable <= 1'b0;
      sampleChannel           <= CHAN_RESET;
      compareEnableBit        <= 1'b0;
      compareGreaterEqual     <= 1'b0;
      config_                 <= CFG_RESET;
      compareHigh             <= 8'h00;
      compareLow              <= 8'h00;
      resultHigh              <= 4'h0;
      resultLow               <= 8'h00;
      analogPinControlMid     <= PIN_CTL_RESET;
      analogPinControlHigh    <= PIN_CTL_RESET;
      busReadData             <= 8'h00;
      interruptRequest        <= 1'b0;
      converterEnabled        <= 1'b0;
      converterActive         <= 1'b0;
      asyncClockRun           <= 1'b0;
      padSyncMeta             <= '0;
      padSync                 <= '0;
      padOutputEnable         <= '0;
      padPullupEnable         <= '0;
      portReadData            <= '0;
    end else begin
      conversionCompleteFlag  <= next_conversionCompleteFlag;
      completeInterruptEnable <= next_completeInterruptEnable;
      sampleChannel           <= next_sampleChannel;
      compareEnableBit        <= next_compareEnableBit;
      compareGreaterEqual     <= next_compareGreaterEqual;
      config_                 <= next_config;
      compareHigh             <= next_compareHigh;
      compareLow              <= next_compareLow;
      resultHigh              <= next_resultHigh;
      resultLow               <= next_resultLow;
      analogPinControlMid     <= next_analogPinControlMid;
      analogPinControlHigh    <= next_analogPinControlHigh;
      busReadData             <= next_busReadData;
      interruptRequest        <= next_conversionCompleteFlag &&
                                 next_completeInterruptEnable;
      converterEnabled        <= next_sampleChannel != CHAN_DISABLED;
      converterActive         <= sarBusy;
      asyncClockRun           <= next_config[CFG_ICLK_LSB +: 2] ==
                                 ICLK_ASYNC &&
                                 (sarBusy || waitMode || stop3Mode);
      padSyncMeta             <= padInput;
      padSync                 <= padSyncMeta;
      padOutputEnable         <= portOutputEnable & ~pinDisable;
      padPullupEnable         <= portPullupEnable & ~pinDisable;
      portReadData            <= padSync & ~pinDisable;
    end
  end

  sequence storeSeq;
    storeResult ##1 conversionCompleteFlag;
  endsequence
  sequence startSeq;
    startConv ##1 sarBusy;
  endsequence

  chan_disable_a: assert property (@(posedge clk) disable iff (!resetn)
    sampleChannel == CHAN_DISABLED |-> !converterEnabled)
    else $error("converter enabled with channel all ones");
  idle_power_a: assert property (@(posedge clk) disable iff (!resetn)
    sarDone && !startConv |-> ##2 !converterActive)
    else $error("converter still active after completion");
  start_busy_a: assert property (@(posedge clk) disable iff (!resetn)
    startConv |-> startSeq ##1 converterActive)
    else $error("start did not wake the converter");
  flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    storeResult |-> storeSeq)
    else $error("complete flag not set after store");
  irq_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    storeResult && completeInterruptEnable && !writeHit
      |=> interruptRequest)
    else $error("interrupt missing after store");
  round_ten_a: assert property (@(posedge clk) disable iff (!resetn)
    storeResult && modeField == MODE_10BIT |=> resultHigh[3:2] == 2'h0)
    else $error("10-bit result wider than ten bits");
  eight_high_a: assert property (@(posedge clk) disable iff (!resetn)
    storeResult && modeField == MODE_8BIT && !writeHit
      |=> $stable(resultHigh))
    else $error("8-bit store touched the high result");
  cmp_block_a: assert property (@(posedge clk) disable iff (!resetn)
    sarDone && compareEnableBit && !compareHit |=> $stable(resultLow))
    else $error("result stored though compare failed");
  pin_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (padOutputEnable & $past(pinDisable)) == '0)
    else $error("disabled pin still driven");
  pin_reset_a: assert property (@(posedge clk)
    $rose(resetn) |-> pinDisable == '0 && inputClockSelect == ICLK_BUS)
    else $error("pin control or clock select wrong after reset");
endmodule : apc_converter_control

// ### design/apc_sar.sv
// successive approximation sequencer driving the trial code
`timescale 1ns/1ps
module apc_sar
  import apc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               start,
  input  wire logic               abort,
  input  wire logic               converterTick,
  input  wire logic               eightBitMode,
  input  wire logic               comparatorHigh,
  output logic                    busy,
  output logic                    done,
  output logic [RAW12_W-1:0]      rawResult,
  output logic [RAW12_W-1:0]      trialCode
);
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TRIAL, SAR_SETTLE}
    apc_sar_e;
  apc_sar_e             state, next_state;
  logic [3:0]           count, next_count;
  logic [3:0]           bitIndex, next_bitIndex;
  logic [RAW12_W-1:0]   next_rawResult, next_trialCode;
  logic                 next_done;
  logic [1:0]           compSync;

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_bitIndex  = bitIndex;
    next_rawResult = rawResult;
    next_trialCode = trialCode;
    next_done      = 1'b0;
    unique case (state)
      SAR_IDLE: ;
      SAR_SAMPLE: if (converterTick) begin
        next_count = count + 4'h1;
        if (count == 4'(SAMPLE_TICKS - 1)) begin
          next_state    = SAR_TRIAL;
          next_bitIndex = MSB_INDEX;
        end
      end
      SAR_TRIAL: if (converterTick) begin
        next_trialCode = rawResult | (12'h001 << bitIndex);
        next_count     = 4'h0;
        next_state     = SAR_SETTLE;
      end
      SAR_SETTLE: begin
        next_count = count + 4'h1;
        if (count == 4'(SETTLE_CYCLES - 1)) begin
          // keep the trial bit only on the synced comparator
          if (compSync[1]) next_rawResult = trialCode;
          // 9-bit result in 8-bit mode, 12-bit otherwise
          if (bitIndex == (eightBitMode ? LSB_INDEX_9 : LSB_INDEX_12))
          begin
            next_state = SAR_IDLE;
            next_done  = 1'b1;
          end else begin
            next_bitIndex = bitIndex - 4'h1;
            next_state    = SAR_TRIAL;
          end
        end
      end
    endcase
    if (abort) begin
      next_state = SAR_IDLE;
      next_done  = 1'b0;
    end
    if (start) begin
      next_state     = SAR_SAMPLE;
      next_count     = 4'h0;
      next_rawResult = 12'h000;
      next_trialCode = 12'h000;
      next_done      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= SAR_IDLE;
      count     <= 4'h0;
      bitIndex  <= 4'h0;
      rawResult <= 12'h000;
      trialCode <= 12'h000;
      done      <= 1'b0;
      busy      <= 1'b0;
      compSync  <= 2'h0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      bitIndex  <= next_bitIndex;
      rawResult <= next_rawResult;
      trialCode <= next_trialCode;
      done      <= next_done;
      busy      <= next_state != SAR_IDLE;
      compSync  <= {compSync[0], comparatorHigh};
    end
  end
endmodule : apc_sar

// ### shared/apc_pkg.sv
// constants shared by the converter control block
package apc_pkg;
  // register offsets (byte address of each 8-bit register)
  localparam logic [3:0] OFS_STATUS_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_COMPARE_CONTROL = 4'h1;
  localparam logic [3:0] OFS_RESULT_HIGH     = 4'h2;
  localparam logic [3:0] OFS_RESULT_LOW      = 4'h3;
  localparam logic [3:0] OFS_COMPARE_HIGH    = 4'h4;
  localparam logic [3:0] OFS_COMPARE_LOW     = 4'h5;
  localparam logic [3:0] OFS_CONFIG          = 4'h6;
  localparam logic [3:0] OFS_PIN_CTL_MID     = 4'h7;
  localparam logic [3:0] OFS_PIN_CTL_HIGH    = 4'h8;
  // field positions
  localparam int FLAG_BIT      = 7;
  localparam int IEN_BIT       = 6;
  localparam int CMP_EN_BIT    = 5;
  localparam int CMP_GE_BIT    = 4;
  localparam int CFG_DIV_LSB   = 5;
  localparam int CFG_MODE_LSB  = 2;
  localparam int CFG_ICLK_LSB  = 0;
  // disabled channel code and values after reset
  localparam logic [4:0] CHAN_DISABLED   = 5'h1f;
  localparam logic [4:0] CHAN_RESET      = 5'h1f;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] PIN_CTL_RESET   = 8'h00;
  // mode, clock source and divide encodings
  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_12BIT = 2'h1;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] ICLK_BUS      = 2'h0;
  localparam logic [1:0] ICLK_BUS_HALF = 2'h1;
  localparam logic [1:0] ICLK_ALT      = 2'h2;
  localparam logic [1:0] ICLK_ASYNC    = 2'h3;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int ASYNC_CLK_PERIOD_NS = 500;
  localparam int ASYNC_DIV_CYCLES    = ASYNC_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_TICKS        = 4;
  localparam int SETTLE_CYCLES       = 3;
  localparam int RAW12_W             = 12;
  localparam int RAW9_W              = 9;
  localparam logic [3:0] MSB_INDEX       = 4'hb;
  localparam logic [3:0] LSB_INDEX_12    = 4'h0;
  localparam logic [3:0] LSB_INDEX_9     = 4'h3;
endpackage : apc_pkg

// ### verification/apc_pin_model.sv
// far side model: analog level on the channel, pad levels, alternate clock
`timescale 1ns/1ps
module apc_pin_model #(
  parameter logic [11:0] LEVEL = 12'h6a6
)(
  input  wire logic [11:0] trialCode,
  output logic             comparatorHigh,
  output logic [15:0]      padInput,
  output logic             alternateClock
);
  assign comparatorHigh = (LEVEL >= trialCode);
  assign padInput = 16'ha5c3;
  initial begin
    alternateClock = 1'b0;
    forever #35 alternateClock = ~alternateClock;
  end
endmodule : apc_pin_model

// ### verification/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top
  import apc_pkg::*;
;
  logic        clk, resetn, busWrite, busRead, comparatorHigh;
  logic        alternateClock, converterActive, converterEnabled;
  logic        asyncClockRun, interruptRequest, waitMode, stop3Mode;
  logic [3:0]  busAddr;
  logic [7:0]  busWriteData, busReadData, rdv;
  logic [15:0] portOutputEnable, padInput, padOutputEnable;
  logic [15:0] padPullupEnable, portReadData;
  logic [4:0]  sampleChannel;
  logic [11:0] trialCode;
  int          err_total, checks;
  apc_converter_control i_apc_converter_control (.clk(clk), .resetn(resetn),
    .busAddr(busAddr), .busWriteData(busWriteData), .busWrite(busWrite),
    .busRead(busRead), .busReadData(busReadData), .waitMode(waitMode),
    .alternateClock(alternateClock), .stop3Mode(stop3Mode),
    .comparatorHigh(comparatorHigh), .portOutputEnable(portOutputEnable),
    .portPullupEnable(~portOutputEnable), .padInput(padInput),
    .padOutputEnable(padOutputEnable), .padPullupEnable(padPullupEnable),
    .portReadData(portReadData), .sampleChannel(sampleChannel),
    .trialCode(trialCode), .converterActive(converterActive),
    .converterEnabled(converterEnabled), .asyncClockRun(asyncClockRun),
    .interruptRequest(interruptRequest));
  apc_pin_model i_apc_pin_model (.trialCode(trialCode),
    .comparatorHigh(comparatorHigh), .padInput(padInput),
    .alternateClock(alternateClock));
  task automatic summarize();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busWriteData <= d;
    busWrite <= 1'b1;
    @(posedge clk);
    busWrite <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk);
    busRead <= 1'b0;
    #1 rdv = busReadData;
  endtask : rd
  task automatic t_reset();
    chk("chan", 5'h1f, sampleChannel);
    chk("enabled", 0, converterEnabled);
    rd(OFS_PIN_CTL_MID);
    chk("mid", 0, rdv);
    rd(OFS_PIN_CTL_HIGH);
    chk("high", 0, rdv);
    rd(OFS_CONFIG);
    chk("cfg", 0, rdv);
    rd(4'hf);
    chk("unmapped", 0, rdv);
  endtask : t_reset
  task automatic t_pins();
    wr(OFS_PIN_CTL_MID, 8'h81);
    wr(OFS_PIN_CTL_HIGH, 8'h42);
    repeat (4) @(posedge clk);
    chk("oe", 16'hf0f0 & ~16'h4281, padOutputEnable);
    chk("pu", 16'h0f0f & ~16'h4281, padPullupEnable);
    chk("port", 16'ha5c3 & ~16'h4281, portReadData);
    rd(OFS_PIN_CTL_MID);
    chk("mid", 8'h81, rdv);
    rd(OFS_PIN_CTL_HIGH);
    chk("high", 8'h42, rdv);
  endtask : t_pins
  task automatic t_convert();
    logic [7:0] cfg [4] = '{8'h64, 8'h29, 8'h42, 8'h67};
    logic [7:0] expH [4] = '{8'h06, 8'h01, 8'h01, 8'h06};
    logic [7:0] expL [4] = '{8'ha6, 8'haa, 8'h6a, 8'ha6};
    logic       run;
    int         n;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CONFIG, cfg[i]);
      wr(OFS_STATUS_CONTROL, 8'h40);
      n = 0;
      run = 1'b0;
      while (interruptRequest !== 1'b1 && n < 30000) begin
        @(posedge clk);
        run |= asyncClockRun;
        n++;
      end
      if (n == 30000) begin
        chk("timeout", 0, 1);
        summarize();
      end
      if (i == 3) chk("async", 1, run);
      chk("enabled", 1, converterEnabled);
      chk("active", 0, converterActive);
      rd(OFS_STATUS_CONTROL);
      chk("status", 8'hc0, rdv);
      rd(OFS_RESULT_HIGH);
      chk("res high", expH[i], rdv);
      rd(OFS_RESULT_LOW);
      chk("res low", expL[i], rdv);
      chk("irq", 0, interruptRequest);
    end
  endtask : t_convert
  task automatic t_compare();
    wr(OFS_CONFIG, 8'h04);
    wr(OFS_COMPARE_HIGH, 8'h07);
    wr(OFS_COMPARE_LOW, 8'h00);
    for (int ge = 1; ge >= 0; ge--) begin
      wr(OFS_COMPARE_CONTROL, ge ? 8'h30 : 8'h20);
      wr(OFS_STATUS_CONTROL, 8'h40);
      repeat (200) @(posedge clk);
      chk("cmp irq", ge ? 0 : 1, interruptRequest);
      rd(OFS_STATUS_CONTROL);
      chk("cmp status", ge ? 8'h40 : 8'hc0, rdv);
      rd(OFS_RESULT_LOW);
      chk("cmp low", 8'ha6, rdv);
    end
    wr(OFS_STATUS_CONTROL, 8'h1f);
    @(posedge clk);
    chk("off", 0, converterEnabled);
    chk("idle", 0, converterActive);
  endtask : t_compare
  task automatic t_modes();
    wr(OFS_CONFIG, 8'h03);
    waitMode <= 1'b1;
    repeat (2) @(posedge clk);
    chk("wait run", 1, asyncClockRun);
    waitMode <= 1'b0;
    stop3Mode <= 1'b1;
    repeat (2) @(posedge clk);
    chk("stop3 run", 1, asyncClockRun);
    stop3Mode <= 1'b0;
    wr(OFS_CONFIG, 8'h00);
    @(posedge clk);
    chk("idle run", 0, asyncClockRun);
  endtask : t_modes
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {resetn, busWrite, busRead, busAddr, busWriteData} = '0;
    portOutputEnable = 16'hf0f0;
    {waitMode, stop3Mode} = 2'h0;
    err_total = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_pins();
    t_convert();
    t_compare();
    t_modes();
    summarize();
  end
endmodule : tb_top
